/* File: rtl/vcd_consts.svh */
`ifndef VCD_CONSTS_SVH
`define VCD_CONSTS_SVH
// dword positions inside the 64-byte entry
`define VCD_DW_CMN 0
`define VCD_DW_NS 1
`define VCD_DW_MPTR 4
`define VCD_DW_DPTR 6
`define VCD_DW_TEN 10
`define VCD_DW_ELEVEN 11
`define VCD_DW_C12 12
`define VCD_DW_C13 13
`define VCD_DW_C14 14
`define VCD_DW_C15 15
// fields of the common first word
`define VCD_OPC_LSB 0
`define VCD_PFS_LSB 14
`define VCD_PFS_PAGE 2'h0
`define VCD_PFS_SGL_A 2'h1
`define VCD_PFS_SGL_B 2'h2
// vendor-specific opcodes start here
`define VCD_OPC_VS 8'hc0
// namespace selector codes
`define VCD_NS_NONE 32'h00000000
`define VCD_NS_ALL 32'hffffffff
// register addresses
`define VCD_A_CTRL 4'h0
`define VCD_A_NSLIM 4'h1
`define VCD_A_STAT 4'h2
`define VCD_A_MASK 4'h3
`define VCD_A_NAMESPACE_SELECTOR 4'h4
// control bits and reset values
`define VCD_C_FMT 0
`define VCD_C_VSCHK 1
`define VCD_CTRL_RST 2'h3
`define VCD_NSLIM_RST 32'h00000001
// event bits
`define VCD_EV_DONE 0
`define VCD_EV_ABORT 1
`define VCD_EV_BCAST 2
`define VCD_EV_W 3
`endif

/* File: rtl/vcd_decode.sv */
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vcd_consts.svh"
module vcd_decode
	import vcd_pkg::*;
(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// entry in
	input wire vcd_entry_t entry,
	input wire logic entry_valid,
	// decoded fields
	output logic decode_valid,
	output vcd_dword_t common_first_word,
	output logic [7:0] opcode,
	output logic [1:0] pointer_form_select,
	output logic pointer_is_sgl,
	output vcd_dword_t namespace_selector,
	output logic all_namespaces,
	output logic abort_invalid_ns,
	output logic [63:0] metadata_pointer,
	output logic [127:0] data_pointer,
	output logic counts_valid,
	output vcd_dword_t data_dword_count,
	output vcd_dword_t metadata_dword_count,
	output vcd_dword_t specific_word_ten,
	output vcd_dword_t specific_word_eleven,
	output vcd_dword_t specific_word_twelve,
	output vcd_dword_t specific_word_thirteen,
	output vcd_dword_t specific_word_fourteen,
	output vcd_dword_t specific_word_fifteen,
	// register port
	input wire logic [3:0] reg_addr,
	input wire vcd_dword_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output vcd_dword_t reg_rdata,
	// interrupt
	output logic irq
);

	// one dword of the entry
	function automatic vcd_dword_t dw(input vcd_entry_t e,
		input int k);
		return e[k*32 +: 32];
	endfunction : dw

	// register state
	logic [1:0] ctrl;
	vcd_dword_t ns_limit;
	vcd_ev_t status;
	vcd_ev_t mask;

	// selected input fields
	wire vcd_dword_t in_cmn = dw(entry, `VCD_DW_CMN);
	wire vcd_dword_t in_ns = dw(entry, `VCD_DW_NS);
	wire vcd_dword_t in_ten = dw(entry, `VCD_DW_TEN);
	wire vcd_dword_t in_elv = dw(entry, `VCD_DW_ELEVEN);
	wire [7:0] in_opc = in_cmn[`VCD_OPC_LSB +: 8];
	wire [1:0] in_pfs = in_cmn[`VCD_PFS_LSB +: 2];
	// reserved dwords 2 and 3 are never read
	wire [63:0] in_mptr = {dw(entry, `VCD_DW_MPTR + 1),
		dw(entry, `VCD_DW_MPTR)};
	wire [127:0] in_dptr = entry[`VCD_DW_DPTR*32 +: 128];

	// namespace checks
	wire in_unused = (in_ns == `VCD_NS_NONE);
	wire in_all = (in_ns == `VCD_NS_ALL);
	wire in_bad = !in_unused && !in_all && (in_ns > ns_limit);
	wire in_vs = (in_opc >= `VCD_OPC_VS);
	// vendor commands obey the check bit only
	wire in_abort = in_bad &&
		(!in_vs || ctrl[`VCD_C_VSCHK]);
	// explicit counts only for enabled vendor format
	wire in_fmt = in_vs && ctrl[`VCD_C_FMT];
	wire in_sgl = (in_pfs == `VCD_PFS_SGL_A) ||
		(in_pfs == `VCD_PFS_SGL_B);
	wire take = ce && entry_valid;

	// decode valid strobe, one cycle per taken entry
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			decode_valid <= 1'b0;
		else if (ce)
			decode_valid <= entry_valid;
	end

	// common fields and namespace result
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			common_first_word <= '0;
			opcode <= '0;
			pointer_form_select <= '0;
			pointer_is_sgl <= 1'b0;
			namespace_selector <= '0;
			all_namespaces <= 1'b0;
			abort_invalid_ns <= 1'b0;
		end else if (take) begin
			common_first_word <= in_cmn;
			opcode <= in_opc;
			pointer_form_select <= in_pfs;
			pointer_is_sgl <= in_sgl;
			namespace_selector <= in_ns;
			all_namespaces <= in_all;
			abort_invalid_ns <= in_abort;
		end
	end

	// pointers travel unchanged
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			metadata_pointer <= '0;
			data_pointer <= '0;
		end else if (take) begin
			metadata_pointer <= in_mptr;
			data_pointer <= in_dptr;
		end
	end

	// the same bytes mean counts or words ten/eleven by format
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			counts_valid <= 1'b0;
			data_dword_count <= '0;
			metadata_dword_count <= '0;
			specific_word_ten <= '0;
			specific_word_eleven <= '0;
		end else if (take) begin
			counts_valid <= in_fmt;
			data_dword_count <= in_fmt ? in_ten : '0;
			metadata_dword_count <= in_fmt ? in_elv : '0;
			specific_word_ten <= in_fmt ? '0 : in_ten;
			specific_word_eleven <= in_fmt ? '0 : in_elv;
		end
	end

	// trailing words are not interpreted here
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			specific_word_twelve <= '0;
			specific_word_thirteen <= '0;
			specific_word_fourteen <= '0;
			specific_word_fifteen <= '0;
		end else if (take) begin
			specific_word_twelve <= dw(entry, `VCD_DW_C12);
			specific_word_thirteen <= dw(entry, `VCD_DW_C13);
			specific_word_fourteen <= dw(entry, `VCD_DW_C14);
			specific_word_fifteen <= dw(entry, `VCD_DW_C15);
		end
	end

	// register decode
	wire wr_ctrl = ce && reg_wr && (reg_addr == `VCD_A_CTRL);
	wire wr_lim = ce && reg_wr && (reg_addr == `VCD_A_NSLIM);
	wire wr_stat = ce && reg_wr && (reg_addr == `VCD_A_STAT);
	wire wr_mask = ce && reg_wr && (reg_addr == `VCD_A_MASK);

	// events raised by this entry
	wire vcd_ev_t ev;
	assign ev[`VCD_EV_DONE] = take;
	assign ev[`VCD_EV_ABORT] = take && in_abort;
	assign ev[`VCD_EV_BCAST] = take && in_all;

	// write one clears; a new event beats the clear
	wire vcd_ev_t clr = wr_stat ? reg_wdata[`VCD_EV_W-1:0] : '0;
	wire vcd_ev_t next_status = (status & ~clr) | ev;

	// control registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl <= `VCD_CTRL_RST;
			ns_limit <= `VCD_NSLIM_RST;
			mask <= '0;
		end else begin
			if (wr_ctrl)
				ctrl <= reg_wdata[1:0];
			if (wr_lim)
				ns_limit <= reg_wdata;
			if (wr_mask)
				mask <= reg_wdata[`VCD_EV_W-1:0];
		end
	end

	// sticky status
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			status <= '0;
		else if (ce)
			status <= next_status;
	end

	// read mux; unmapped addresses read zero
	vcd_dword_t rd_mux;
	always_comb begin
		rd_mux = '0;
		unique case (reg_addr)
			`VCD_A_CTRL: rd_mux = {30'h0, ctrl};
			`VCD_A_NSLIM: rd_mux = ns_limit;
			`VCD_A_STAT: rd_mux = {29'h0, status};
			`VCD_A_MASK: rd_mux = {29'h0, mask};
			`VCD_A_NAMESPACE_SELECTOR: rd_mux = namespace_selector;
			default: rd_mux = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			reg_rdata <= '0;
		else if (ce)
			reg_rdata <= reg_rd ? rd_mux : '0;
	end

	// level interrupt from unmasked sticky bits
	assign irq = |(status & mask);

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_take;
		ce && entry_valid;
	endsequence

	sequence s_bad_std;
		s_take ##0 (in_bad && !in_vs);
	endsequence

	sequence s_bad_vs_off;
		s_take ##0 (in_bad && in_vs && !ctrl[`VCD_C_VSCHK]);
	endsequence

	first_word_a: assert property (s_take |=> decode_valid &&
		common_first_word == $past(in_cmn))
		else $error("first word not passed");

	ns_take_a: assert property (s_take |=>
		namespace_selector == $past(in_ns))
		else $error("namespace selector wrong");

	all_ns_a: assert property (s_take ##1 decode_valid |->
		all_namespaces == (namespace_selector == `VCD_NS_ALL))
		else $error("broadcast flag wrong");

	// the set beats a same-cycle clear, so the event bit is up at once
	ns_abort_a: assert property (s_bad_std |=>
		abort_invalid_ns && status[`VCD_EV_ABORT])
		else $error("invalid namespace not aborted");

	vs_free_a: assert property (s_bad_vs_off |=>
		!abort_invalid_ns)
		else $error("vendor namespace check not released");

	ptr_pass_a: assert property (s_take |=>
		data_pointer == $past(in_dptr) &&
		metadata_pointer == $past(in_mptr))
		else $error("pointer fields altered");

	count_fmt_a: assert property (s_take ##0 in_fmt |=>
		data_dword_count == $past(in_ten) &&
		metadata_dword_count == $past(in_elv) &&
		specific_word_ten == '0)
		else $error("dword counts wrong");

	std_fmt_a: assert property (s_take ##0 !in_vs |=>
		!counts_valid && specific_word_eleven == $past(in_elv))
		else $error("standard command given counts");

	tail_pass_a: assert property (s_take |=>
		specific_word_fifteen == $past(dw(entry, `VCD_DW_C15)))
		else $error("trailing words altered");

	sgl_sel_a: assert property (s_take |=>
		pointer_is_sgl == (pointer_form_select == `VCD_PFS_SGL_A ||
		pointer_form_select == `VCD_PFS_SGL_B))
		else $error("pointer form decode wrong");

	irq_lvl_a: assert property ((status & mask) != '0 |-> irq)
		else $error("interrupt not raised");

	rd_once_a: assert property (!reg_rd && ce |=> reg_rdata == '0)
		else $error("read data held too long");

endmodule : vcd_decode
`default_nettype wire

/* File: rtl/vcd_pkg.sv */
`include "vcd_consts.svh"
package vcd_pkg;
	typedef logic [31:0] vcd_dword_t;
	typedef logic [511:0] vcd_entry_t;
	typedef logic [`VCD_EV_W-1:0] vcd_ev_t;
endpackage : vcd_pkg

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import vcd_pkg::*;
	logic mclk, rst, ce, entry_valid, reg_wr, reg_rd, use_ns, irq;
	logic decode_valid, pointer_is_sgl, all_namespaces, abort_invalid_ns;
	logic counts_valid;
	logic [7:0] opc, opcode;
	logic [1:0] pfs, pointer_form_select;
	logic [3:0] reg_addr;
	logic [63:0] metadata_pointer;
	logic [127:0] data_pointer;
	vcd_dword_t reg_wdata, ns, seed, reg_rdata, common_first_word;
	vcd_dword_t namespace_selector, data_dword_count, metadata_dword_count;
	vcd_dword_t specific_word_ten, specific_word_eleven;
	vcd_dword_t specific_word_twelve, specific_word_thirteen;
	vcd_dword_t specific_word_fourteen, specific_word_fifteen;
	vcd_entry_t entry;
	int error_cnt, n_tests;
	// host model and decoder
	vcd_host host (.opc, .pfs, .use_ns, .ns, .seed, .entry);
	vcd_decode uut (.mclk, .rst, .ce, .entry, .entry_valid, .decode_valid,
		.common_first_word, .opcode, .pointer_form_select, .pointer_is_sgl,
		.namespace_selector, .all_namespaces, .abort_invalid_ns,
		.metadata_pointer, .data_pointer, .counts_valid, .data_dword_count,
		.metadata_dword_count, .specific_word_ten, .specific_word_eleven,
		.specific_word_twelve, .specific_word_thirteen,
		.specific_word_fourteen, .specific_word_fifteen, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
	task automatic chk(input logic [127:0] s, input logic [127:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t saw %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// one-cycle write; returns just after the edge that takes it
	task automatic wr(input logic [3:0] a, input vcd_dword_t d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd_chk(input logic [3:0] a, input vcd_dword_t e);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd_chk
	// new seed each entry so stale fields never match by luck
	task automatic send(input logic [7:0] o, input logic [1:0] f,
		input logic u, input vcd_dword_t n);
		@(posedge mclk);
		opc <= o;
		pfs <= f;
		use_ns <= u;
		ns <= n;
		seed <= seed + 32'h01030507;
		entry_valid <= 1'b1;
		@(posedge mclk);
		entry_valid <= 1'b0;
		#1;
	endtask : send
	task automatic fields(input logic cv);
		chk(decode_valid, 1'b1);
		chk(common_first_word, {seed[31:16], pfs, seed[13:8], opc});
		chk({opcode, pointer_form_select}, {opc, pfs});
		chk(namespace_selector, use_ns ? ns : 32'h0);
		chk(metadata_pointer, {seed + 32'h5, seed + 32'h4});
		chk(data_pointer, {seed + 32'h9, seed + 32'h8,
			seed + 32'h7, seed + 32'h6});
		chk(counts_valid, cv);
		chk(data_dword_count, cv ? seed + 32'ha : 32'h0);
		chk(metadata_dword_count, cv ? seed + 32'hb : 32'h0);
		chk(specific_word_ten, cv ? 32'h0 : seed + 32'ha);
		chk(specific_word_eleven, cv ? 32'h0 : seed + 32'hb);
		chk({specific_word_fifteen, specific_word_fourteen,
			specific_word_thirteen, specific_word_twelve}, {seed + 32'hf,
			seed + 32'he, seed + 32'hd, seed + 32'hc});
		chk(pointer_is_sgl, pfs == 2'h1 || pfs == 2'h2);
	endtask : fields
	task automatic t_std;
		rd_chk(4'h0, 32'h3);
		rd_chk(4'h1, 32'h1);
		wr(4'h9, 32'hffffffff);
		rd_chk(4'h9, 32'h0);
		for (int f = 0; f < 4; f++) begin
			send(8'h02, 2'(f), 1'b1, 32'h1);
			fields(1'b0);
		end
		send(8'hbf, 2'h1, 1'b1, 32'h1);
		fields(1'b0);
		send(8'hc0, 2'h1, 1'b1, 32'h1);
		fields(1'b1);
		send(8'hff, 2'h2, 1'b1, 32'h1);
		fields(1'b1);
		wr(4'h0, 32'h2);
		send(8'hc0, 2'h0, 1'b1, 32'h1);
		fields(1'b0);
		wr(4'h0, 32'h3);
		$display("format test done");
	endtask : t_std
	task automatic t_ns;
		wr(4'h2, 32'h7);
		send(8'h02, 2'h0, 1'b1, 32'hffffffff);
		chk({all_namespaces, abort_invalid_ns}, 2'h2);
		rd_chk(4'h2, 32'h5);
		send(8'h02, 2'h0, 1'b1, 32'h2);
		chk({all_namespaces, abort_invalid_ns}, 2'h1);
		send(8'h02, 2'h0, 1'b0, 32'h2);
		chk(abort_invalid_ns, 1'b0);
		rd_chk(4'h4, 32'h0);
		wr(4'h1, 32'h8);
		send(8'h02, 2'h0, 1'b1, 32'h8);
		chk(abort_invalid_ns, 1'b0);
		send(8'hc0, 2'h0, 1'b1, 32'h9);
		chk(abort_invalid_ns, 1'b1);
		wr(4'h0, 32'h1);
		send(8'hc0, 2'h0, 1'b1, 32'h9);
		chk(abort_invalid_ns, 1'b0);
		wr(4'h0, 32'h3);
		wr(4'h1, 32'h1);
		$display("namespace test done");
	endtask : t_ns
	task automatic t_irq;
		wr(4'h2, 32'h7);
		wr(4'h3, 32'h2);
		send(8'h02, 2'h0, 1'b1, 32'h1);
		chk(irq, 1'b0);
		send(8'h02, 2'h0, 1'b1, 32'h3);
		chk(irq, 1'b1);
		send(8'h02, 2'h0, 1'b1, 32'h1);
		chk(irq, 1'b1);
		wr(4'h2, 32'h2);
		chk(irq, 1'b0);
		wr(4'h3, 32'h0);
		rd_chk(4'h2, 32'h1);
		// a frozen block must ignore the entry entirely
		@(posedge mclk);
		ce <= 1'b0;
		send(8'h02, 2'h0, 1'b1, 32'h2);
		chk({decode_valid, namespace_selector}, 33'h1);
		@(posedge mclk);
		ce <= 1'b1;
		$display("interrupt test done");
	endtask : t_irq
	// watchdog: a hung run ends as a failure
	initial begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		stop_test();
	end
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		{rst, ce, entry_valid, reg_wr, reg_rd, use_ns} = 6'h31;
		{opc, pfs, reg_addr, reg_wdata, ns, seed} = '0;
		error_cnt = 0;
		n_tests = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_std();
		t_ns();
		t_irq();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire

/* File: sim/vcd_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host side: lays out a 64-byte entry from a few command fields
module vcd_host
	import vcd_pkg::*;
(
	// command fields
	input wire logic [7:0] opc,
	input wire logic [1:0] pfs,
	input wire logic use_ns,
	input wire vcd_dword_t ns,
	input wire vcd_dword_t seed,
	// entry out
	output var vcd_entry_t entry
);
	// every dword but dwords 1 to 3 (ns or zero in dword 1, zeroed dwords 2 and 3) differs, so a swapped or shifted field shows up
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			entry[32*k +: 32] = seed + 32'(k);
		end
		entry[31:0] = {seed[31:16], pfs, seed[13:8], opc};
		entry[63:32] = use_ns ? ns : 32'h00000000;
		entry[127:64] = 64'h0;
	end
endmodule : vcd_host
`default_nettype wire
